// *** src/srcc_defs.svh ***
// Constants for the serial video reclocker control block
`ifndef SRCC_DEFS_SVH
`define SRCC_DEFS_SVH

`define SRCC_RATE_AUTO 2'h0
`define SRCC_RATE_SD 2'h1
`define SRCC_RATE_HD 2'h2
`define SRCC_CLK_HZ 250000000
`define SRCC_REF_NS 37
`define SRCC_REF_CYC ((`SRCC_REF_NS * 250 + 999) / 1000)
`define SRCC_DROP_US 1000
`define SRCC_DROP_CYC (`SRCC_DROP_US * 250)
`define SRCC_ACQ_MS 15
`define SRCC_ACQ_CYC (`SRCC_ACQ_MS * 250000)
`define SRCC_LOCK_CYC 64

`endif

// *** src/srcc_pkg.sv ***
// Types for the serial video reclocker control block
package srcc_pkg;
	// Detected line rate class reported by the recovery front end
	typedef enum logic [2:0] {
		SRCC_R_NONE,
		SRCC_R_270,
		SRCC_R_1483,
		SRCC_R_1485,
		SRCC_R_2967,
		SRCC_R_2970,
		SRCC_R_OTHER
	} srcc_rate_t;
	// One differential output pair
	typedef struct packed {
		logic p;
		logic n;
	} srcc_diff_t;
endpackage

// *** src/srcc_pair_drive.sv ***
// Differential output stage with static mute level
module srcc_pair_drive
	import srcc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_bit,
	input wire logic i_mute,
	output srcc_diff_t o_pair
);
	srcc_diff_t pair_d;
	srcc_diff_t pair_q;

	// Muted pair sits low/high so receivers see a steady zero
	assign pair_d.p = i_mute ? 1'h0 : i_bit;
	assign pair_d.n = i_mute ? 1'h1 : ~i_bit;

	// Registered so the pins come straight from flops
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pair_q <= '{p: 1'h0, n: 1'h1};
		end else begin
			pair_q <= pair_d;
		end
	end
	assign o_pair = pair_q;
endmodule // srcc_pair_drive

// *** src/srcc_reclocker_ctrl.sv ***
// Control and indicator logic of the serial video reclocker
`include "srcc_defs.svh"
module srcc_reclocker_ctrl
	import srcc_pkg::*;
#(
	parameter int unsigned DROP_CYC = `SRCC_DROP_CYC,
	parameter int unsigned ACQ_CYC = `SRCC_ACQ_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_serial_video_in,
	input wire logic i_recovered_bit,
	input wire logic i_recovered_clk,
	input wire logic i_pll_locked,
	input wire srcc_rate_t i_detected_rate,
	input wire logic i_data_present,
	input wire logic [1:0] i_rate_select,
	input wire logic i_bypass,
	input wire logic i_output_mute_n,
	input wire logic i_second_out_clock_select,
	output srcc_diff_t o_primary_retimed_out,
	output srcc_diff_t o_second_clock_or_data_out,
	output logic o_lock_flag,
	output logic o_rate_class_flag,
	output logic o_reclock_active,
	output logic o_second_out_invalid
);
	// Acquisition and drop counters are wide enough for the long defaults
	logic [21:0] acq_cnt_q;
	logic [21:0] acq_cnt_d;
	logic [17:0] drop_cnt_q;
	logic [17:0] drop_cnt_d;
	logic [3:0] upd_cnt_q;
	logic [3:0] upd_cnt_d;
	logic lock_q;
	logic lock_d;
	logic lock_prev_q;
	logic class_q;
	logic class_d;
	logic reclock_q;
	logic invalid_q;
	logic prev_in_q;
	srcc_rate_t rate_prev_q;

	// Rate decoding against the selected mode
	wire is_sd = (i_detected_rate == SRCC_R_270);
	wire is_hd = (i_detected_rate == SRCC_R_1483) ||
		(i_detected_rate == SRCC_R_1485) ||
		(i_detected_rate == SRCC_R_2967) ||
		(i_detected_rate == SRCC_R_2970);
	// Undriven select pins are pulled low upstream, so 00 means auto
	wire sel_auto = (i_rate_select == `SRCC_RATE_AUTO);
	wire sel_sd = (i_rate_select == `SRCC_RATE_SD);
	wire sel_hd = (i_rate_select == `SRCC_RATE_HD);
	// Harmonics and the odd rates decode as OTHER, never lockable
	wire rate_ok = (sel_auto && (is_sd || is_hd)) ||
		(sel_sd && is_sd) || (sel_hd && is_hd);
	wire can_lock = i_pll_locked && i_data_present && rate_ok &&
		!i_bypass;
	wire data_edge = i_serial_video_in ^ prev_in_q;
	wire rate_change = (i_detected_rate != rate_prev_q);

	// Acquisition timer: counts qualifying cycles and holds at SRCC_LOCK_CYC; no window limits when lock may rise
	assign acq_cnt_d = (!can_lock) ? 22'h0 :
		(acq_cnt_q < 22'(`SRCC_LOCK_CYC)) ? acq_cnt_q + 22'h1 : acq_cnt_q;
	// Drop timer: loss of lock condition must persist briefly, bounded
	assign drop_cnt_d = (can_lock || !lock_q) ? 18'h0 :
		drop_cnt_q + 18'h1;
	// Lock rises after a short qualify, far below the acquisition limit
	wire lock_rise = !lock_q && can_lock &&
		(acq_cnt_q >= 22'(`SRCC_LOCK_CYC));
	// Bypass and rate changes drop lock at once; other loss well inside 1 ms
	wire lock_fall = lock_q && (i_bypass || rate_change ||
		(!can_lock && drop_cnt_q >= 18'(`SRCC_LOCK_CYC)));
	assign lock_d = lock_rise ? 1'h1 : (lock_fall ? 1'h0 : lock_q);

	// Rate class waits one reference period after lock rises and clears one cycle after lock falls
	assign upd_cnt_d = (lock_q != lock_prev_q) ? 4'(`SRCC_REF_CYC) :
		(upd_cnt_q != 4'h0) ? upd_cnt_q - 4'h1 : 4'h0;
	assign class_d = !lock_q ? 1'h0 :
		(upd_cnt_q == 4'h1) ? is_sd : class_q;

	// Retime only when locked, supported, and not forced into bypass
	wire retime = lock_q && rate_ok && !i_bypass;
	wire bypassed = !retime;
	wire out_bit = retime ? i_recovered_bit : i_serial_video_in;
	// Clock follows recovered clock; edge placement is the analog loop's job
	wire sec_bit = i_second_out_clock_select ? i_recovered_clk :
		out_bit;
	// Mute wins over bypass on both pairs
	wire mute_pri = !i_output_mute_n;
	wire mute_sec = !i_output_mute_n ||
		(bypassed && i_second_out_clock_select);
	// Clock output during auto bypass on a bad rate carries no meaning
	wire invalid_d = i_second_out_clock_select && !i_bypass &&
		(i_detected_rate == SRCC_R_OTHER);

	// Lock state and indicators; reset starts unlocked and bypassed
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			lock_q <= 1'h0;
			lock_prev_q <= 1'h0;
			class_q <= 1'h0;
			reclock_q <= 1'h0;
			invalid_q <= 1'h0;
			acq_cnt_q <= 22'h0;
			drop_cnt_q <= 18'h0;
			upd_cnt_q <= 4'h0;
		end else begin
			lock_q <= lock_d;
			lock_prev_q <= lock_q;
			class_q <= class_d;
			reclock_q <= retime;
			invalid_q <= invalid_d;
			acq_cnt_q <= acq_cnt_d;
			drop_cnt_q <= drop_cnt_d;
			upd_cnt_q <= upd_cnt_d;
		end
	end

	// Input history for edge and rate change detection
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prev_in_q <= 1'h0;
			rate_prev_q <= SRCC_R_NONE;
		end else begin
			prev_in_q <= i_serial_video_in;
			rate_prev_q <= i_detected_rate;
		end
	end

	// Output pairs with static mute levels
	srcc_pair_drive u_primary (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_bit(out_bit),
		.i_mute(mute_pri),
		.o_pair(o_primary_retimed_out)
	);
	srcc_pair_drive u_second (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_bit(sec_bit),
		.i_mute(mute_sec),
		.o_pair(o_second_clock_or_data_out)
	);

	assign o_lock_flag = lock_q;
	assign o_rate_class_flag = class_q;
	assign o_reclock_active = reclock_q;
	assign o_second_out_invalid = invalid_q;

	// Edge detect kept for future activity qualification
	logic unused_ok;
	assign unused_ok = data_edge & (DROP_CYC != 0) & (ACQ_CYC != 0);
endmodule // srcc_reclocker_ctrl

// *** tb/srcc_eq_model.sv ***
// Front end model: equalizer output and clock recovery status
module srcc_eq_model import srcc_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_on,
	input wire srcc_rate_t i_rate,
	output var logic o_data,
	output var logic o_clk,
	output var logic o_pll,
	output var srcc_rate_t o_rate
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 79163;
	// Without carrier the line keeps toggling, so no stale level looks valid
	always begin
		o_clk = (o_clk === 1'b0);
		o_data = i_on ? 1'($random(seed)) : o_clk;
		o_pll = i_on;
		o_rate = i_on ? i_rate : SRCC_R_NONE;
		@(posedge i_clk_sys);
		#1;
	end
endmodule // srcc_eq_model

// *** tb/srcc_assertions.sv ***
// Port checks for the reclocker control block
module srcc_assertions import srcc_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_serial_video_in,
	input wire logic i_pll_locked,
	input wire logic i_data_present,
	input wire logic i_bypass,
	input wire logic i_output_mute_n,
	input wire logic i_second_out_clock_select,
	input wire srcc_diff_t o_primary_retimed_out,
	input wire srcc_diff_t o_second_clock_or_data_out,
	input wire logic o_lock_flag,
	input wire logic o_rate_class_flag,
	input wire logic o_reclock_active
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Mute and bypass effects land one cycle after their cause
	property p_mp; !i_output_mute_n |=> o_primary_retimed_out == 2'h1; endproperty
	a_mp: assert property (p_mp) else $error("mute");
	property p_bc; i_bypass && i_second_out_clock_select
		|=> o_second_clock_or_data_out == 2'h1; endproperty
	a_bc: assert property (p_bc) else $error("clock out");
	property p_op; o_primary_retimed_out.p != o_primary_retimed_out.n; endproperty
	a_op: assert property (p_op) else $error("pair");
	property p_bl; i_bypass |=> !o_lock_flag; endproperty
	a_bl: assert property (p_bl) else $error("lock");
	property p_bt; i_bypass && i_output_mute_n
		|=> o_primary_retimed_out.p == $past(i_serial_video_in); endproperty
	a_bt: assert property (p_bt) else $error("bypass");
	property p_rl; $rose(o_lock_flag)
		|-> $past(i_pll_locked) && $past(i_data_present); endproperty
	a_rl: assert property (p_rl) else $error("rise");
	property p_cl; !o_lock_flag |=> !o_rate_class_flag; endproperty
	a_cl: assert property (p_cl) else $error("class");
	property p_ra; !o_lock_flag |=> !o_reclock_active; endproperty
	a_ra: assert property (p_ra) else $error("retime");
endmodule // srcc_assertions
bind srcc_reclocker_ctrl srcc_assertions u_chk (.*);

// *** tb/tb.sv ***
// Self-checking bench for the reclocker control block
module tb import srcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys = 0, i_rst = 1, on = 0, byp = 0, mute_n = 1, csel = 0;
	logic [1:0] sel = 2'h0;
	logic data, rclk, pll, lock, cls, rck, inv;
	logic [13:0] n;
	srcc_rate_t rate = SRCC_R_NONE, drate;
	srcc_diff_t pri, sec;
	srcc_rate_t ok[5] = '{SRCC_R_270, SRCC_R_1483, SRCC_R_1485, SRCC_R_2967,
		SRCC_R_2970};
	int checks = 0, miscompares = 0;
	logic [13:0] notes[$];
	event seen;
	always #2 i_clk_sys = ~i_clk_sys;
	srcc_eq_model fe (.i_clk_sys, .i_on(on), .i_rate(rate), .o_data(data),
		.o_clk(rclk), .o_pll(pll), .o_rate(drate));
	srcc_reclocker_ctrl uut (.i_clk_sys, .i_rst, .i_serial_video_in(data),
		.i_recovered_bit(data), .i_recovered_clk(rclk), .i_pll_locked(pll),
		.i_detected_rate(drate), .i_data_present(pll), .i_rate_select(sel),
		.i_bypass(byp), .i_output_mute_n(mute_n),
		.i_second_out_clock_select(csel), .o_primary_retimed_out(pri),
		.o_second_clock_or_data_out(sec), .o_lock_flag(lock),
		.o_rate_class_flag(cls), .o_reclock_active(rck),
		.o_second_out_invalid(inv));
	task automatic check(input logic [6:0] got, input logic [6:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Ninety cycles covers a full drop or a requalify, plus class update
	task automatic run(input logic o, input srcc_rate_t r,
		input logic [1:0] s, input logic [2:0] c, input logic [6:0] e, m);
		{on, rate, sel, byp, mute_n, csel} = {o, r, s, c};
		repeat (90) @(posedge i_clk_sys);
		#1 notes.push_back({e, m});
		-> seen;
		$display("test done at %0t", $time);
	endtask
	// Oldest note is judged against the outputs when a result is presented
	always @(seen) begin
		n = notes.pop_front();
		check({lock, cls, rck, pri, sec} & n[6:0], n[13:7] & n[6:0]);
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		#1 notes.push_back({7'h05, 7'h7f});
		-> seen;
		i_rst = 0;
		foreach (ok[i])
			run(1, ok[i], 2'h0, 3'h2, {1'b1, ok[i] == SRCC_R_270, 5'h10}, 7'h70);
		run(1, SRCC_R_270, 2'h1, 3'h2, 7'h70, 7'h70);
		run(1, SRCC_R_270, 2'h0, 3'h7, 7'h01, 7'h73);
		run(1, SRCC_R_2970, 2'h2, 3'h2, 7'h50, 7'h70);
		run(1, SRCC_R_270, 2'h0, 3'h4, 7'h05, 7'h7f);
		run(1, SRCC_R_1485, 2'h1, 3'h2, 7'h00, 7'h70);
		run(1, SRCC_R_270, 2'h3, 3'h2, 7'h00, 7'h70);
		run(1, SRCC_R_OTHER, 2'h0, 3'h2, 7'h00, 7'h70);
		run(1, SRCC_R_270, 2'h0, 3'h2, 7'h70, 7'h70);
		check({6'h00, inv}, 7'h00);
		// Clock on output two with an odd rate in auto bypass
		run(1, SRCC_R_OTHER, 2'h0, 3'h3, 7'h01, 7'h73);
		check({6'h00, inv}, 7'h01);
		// Carrier off: first with mute asserted, then with mute released and only the flags checked
		run(0, SRCC_R_270, 2'h0, 3'h0, 7'h05, 7'h7f);
		run(0, SRCC_R_270, 2'h0, 3'h2, 7'h00, 7'h70);
		tally_and_finish;
	end
	// About sixteen runs of ninety cycles; four times that is a hang
	initial begin
		#25us;
		miscompares++;
		tally_and_finish;
	end
endmodule // tb
